// ### hw/lscrb_pkg.sv
// register map, field positions and reset values of the lin/sci register bank
// assumes an axi4-lite master with 32-bit data on a single 20 MHz clock
`default_nettype none

package lscrb_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_MODULE_RESET_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_GLOBAL_CONTROL       = 8'h04;
    localparam logic [7:0] ADDR_FRAME_FORMAT         = 8'h08;
    localparam logic [7:0] ADDR_RECEIVE_BUFFER_HIGH  = 8'h0C;
    localparam logic [7:0] ADDR_IDENTIFIER_MASK      = 8'h10;
    localparam logic [7:0] ADDR_IDENTIFIER           = 8'h14;
    localparam logic [7:0] ADDR_TRANSMIT_BUFFER_LOW  = 8'h18;
    localparam logic [7:0] ADDR_TRANSMIT_BUFFER_HIGH = 8'h1C;
    localparam logic [7:0] ADDR_MAX_BAUD_SELECT      = 8'h20;
    localparam logic [7:0] ADDR_TEST_CONTROL         = 8'h24;
    localparam logic [7:0] ADDR_TX_STATUS            = 8'h28;

    // ************************************************************
    // writable-bit masks per register, split by mode
    // ************************************************************
    // global control: any-mode bits, lin-only bits, compat-only bits
    localparam logic [31:0] GCR_MASK_ANY    = 32'h0303_04E7;
    localparam logic [31:0] GCR_MASK_LIN    = 32'h0000_3A00;
    localparam logic [31:0] GCR_MASK_COMPAT = 32'h0000_0118;
    // frame format: length any mode, char compat only
    localparam logic [31:0] FMT_MASK_ANY    = 32'h0007_0000;
    localparam logic [31:0] FMT_MASK_COMPAT = 32'h0000_0007;
    // identifier: slave task byte and id byte, lin only
    localparam logic [31:0] ID_MASK_LIN     = 32'h0000_FFFF;
    // max baud: lin only
    localparam logic [31:0] MBR_MASK_LIN    = 32'h0000_1FFF;
    // test control: all writable bits in any mode
    localparam logic [31:0] TST_MASK_ANY    = 32'hF71F_0F03;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int RESET_BIT_POS    = 0;
    localparam int LIN_MODE_POS     = 6;
    localparam int TX_ENABLE_POS    = 25;
    localparam int RX_ENABLE_POS    = 24;

    // ************************************************************
    // reset values and axi response codes
    // ************************************************************
    localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;
    localparam logic [1:0]  AXI_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  AXI_RESP_SLVERR = 2'h2;

    // write channel bundle handed to the register logic
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } lscrb_wreq_t;

endpackage

`default_nettype wire

// ### hw/lscrb_bank.sv
// register bank of a combined lin / sci-compatible serial module
// faces an axi4-lite master; the serial engine sits on the engine-side ports
`default_nettype none

// Function
// - writing reset bit releases or resets module
// - reset bit reads current module reset state
// - bits 31 to 1 read zero
// - reset bit written only with privileged gate
// - reset bit works in both modes
// - lin-only fields written only in lin
// - compat-only fields written only in compat
// - transmit transfers only when transmit enabled
module lscrb_bank (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // privileged write gate, from cpu logic on this clock
    input  wire logic        privileged_write_gate,
    // engine side
    output logic             module_run,
    output logic             lin_mode,
    output logic             receive_enable_bit,
    input  wire logic        transmit_load_req,
    output logic             transmit_load_ack,
    output logic [63:0]      transmit_shift_register,
    input  wire logic [31:0] receive_data_high,
    input  wire logic [7:0]  received_id,
    input  wire logic [7:0]  rx_id_mask,
    input  wire logic [7:0]  tx_id_mask,
    // decoded config for the engine
    output logic [31:0]      frame_format,
    output logic [31:0]      identifier_cfg,
    output logic [31:0]      max_baud_select,
    output logic [31:0]      test_control
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                aw_held;
        logic                w_held;
        lscrb_pkg::lscrb_wreq_t wreq;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic                reset_bit;
        logic [31:0]         global_control;
        logic [31:0]         frame_format;
        logic [31:0]         identifier;
        logic [31:0]         tx_low;
        logic [31:0]         tx_high;
        logic [31:0]         max_baud;
        logic [31:0]         test_control;
        logic [63:0]         shift;
        logic                loads;
    } lscrb_state_t;

    lscrb_state_t state;
    lscrb_state_t next_state;

    // merge write data into a register under byte strobes and a writable mask
    function automatic logic [31:0] lscrb_merge(input logic [31:0] old_val,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  strb,
                                                input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_val & ~m) | (wdata & m);
    endfunction

    // writable mask for a mixed register given the current mode
    function automatic logic [31:0] lscrb_mode_mask(input logic [31:0] any_m,
                                                    input logic [31:0] lin_m,
                                                    input logic [31:0] cmp_m,
                                                    input logic        in_lin);
        return any_m | (in_lin ? lin_m : cmp_m);
    endfunction


    // decoded mode and run state, shared by the write and load paths
    logic        in_lin;
    logic        do_write;
    logic        in_run;
    logic [31:0] rd_word;
    logic        rd_hit;

    assign in_lin = state.global_control[lscrb_pkg::LIN_MODE_POS];
    assign in_run = state.reset_bit;

    // ************************************************************
    // read decode
    // ************************************************************
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            lscrb_pkg::ADDR_MODULE_RESET_CONTROL: rd_word = {31'h0000_0000, state.reset_bit};
            lscrb_pkg::ADDR_GLOBAL_CONTROL:       rd_word = state.global_control;
            lscrb_pkg::ADDR_FRAME_FORMAT:         rd_word = state.frame_format;
            lscrb_pkg::ADDR_RECEIVE_BUFFER_HIGH:  rd_word = receive_data_high;
            // masks come live from the engine, never stored here
            lscrb_pkg::ADDR_IDENTIFIER_MASK:      rd_word = {8'h00, rx_id_mask,
                                                             8'h00, tx_id_mask};
            lscrb_pkg::ADDR_IDENTIFIER:           rd_word = {8'h00, received_id,
                                                             state.identifier[15:0]};
            lscrb_pkg::ADDR_TRANSMIT_BUFFER_LOW:  rd_word = state.tx_low;
            lscrb_pkg::ADDR_TRANSMIT_BUFFER_HIGH: rd_word = state.tx_high;
            lscrb_pkg::ADDR_MAX_BAUD_SELECT:      rd_word = state.max_baud;
            lscrb_pkg::ADDR_TEST_CONTROL:         rd_word = state.test_control;
            // bit 0 tells software a load has happened since run
            lscrb_pkg::ADDR_TX_STATUS:            rd_word = {16'h0000,
                                                             state.loads ? 16'h0001 : 16'h0000};
            // unmapped: data zero, slave error flagged below
            default:                              rd_hit  = 1'b0;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_state = state;
        do_write   = 1'b0;

        // capture address and data independently, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_held   = 1'b1;
            next_state.wreq.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_held    = 1'b1;
            next_state.wreq.data = s_axi_wdata;
            next_state.wreq.strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end


        // both halves held and no response pending: commit
        // the mode seen is the one before this write, so a mode change
        // and a mode-restricted field in one word cannot race
        if (state.aw_held && state.w_held && !state.bvalid) begin
            do_write           = 1'b1;
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = lscrb_pkg::AXI_RESP_OKAY;
            case (state.wreq.addr)
                lscrb_pkg::ADDR_MODULE_RESET_CONTROL: begin
                    if (privileged_write_gate && state.wreq.strb[0]) begin
                        next_state.reset_bit = state.wreq.data[lscrb_pkg::RESET_BIT_POS];
                    end
                end
                lscrb_pkg::ADDR_GLOBAL_CONTROL:
                    next_state.global_control = lscrb_merge(state.global_control,
                        state.wreq.data, state.wreq.strb,
                        lscrb_mode_mask(lscrb_pkg::GCR_MASK_ANY, lscrb_pkg::GCR_MASK_LIN,
                                        lscrb_pkg::GCR_MASK_COMPAT, in_lin));
                lscrb_pkg::ADDR_FRAME_FORMAT:
                    next_state.frame_format = lscrb_merge(state.frame_format,
                        state.wreq.data, state.wreq.strb,
                        lscrb_mode_mask(lscrb_pkg::FMT_MASK_ANY, 32'h0000_0000,
                                        lscrb_pkg::FMT_MASK_COMPAT, in_lin));
                lscrb_pkg::ADDR_IDENTIFIER:
                    next_state.identifier = lscrb_merge(state.identifier,
                        state.wreq.data, state.wreq.strb,
                        lscrb_mode_mask(32'h0000_0000, lscrb_pkg::ID_MASK_LIN,
                                        32'h0000_0000, in_lin));
                lscrb_pkg::ADDR_TRANSMIT_BUFFER_LOW:
                    next_state.tx_low = lscrb_merge(state.tx_low, state.wreq.data,
                        state.wreq.strb, 32'hFFFF_FFFF);
                lscrb_pkg::ADDR_TRANSMIT_BUFFER_HIGH:
                    next_state.tx_high = lscrb_merge(state.tx_high, state.wreq.data,
                        state.wreq.strb, 32'hFFFF_FFFF);
                lscrb_pkg::ADDR_MAX_BAUD_SELECT:
                    next_state.max_baud = lscrb_merge(state.max_baud,
                        state.wreq.data, state.wreq.strb,
                        lscrb_mode_mask(32'h0000_0000, lscrb_pkg::MBR_MASK_LIN,
                                        32'h0000_0000, in_lin));
                lscrb_pkg::ADDR_TEST_CONTROL:
                    next_state.test_control = lscrb_merge(state.test_control,
                        state.wreq.data, state.wreq.strb, lscrb_pkg::TST_MASK_ANY);
                lscrb_pkg::ADDR_RECEIVE_BUFFER_HIGH,
                lscrb_pkg::ADDR_IDENTIFIER_MASK,
                lscrb_pkg::ADDR_TX_STATUS: ; // read-only, write ignored
                default:
                    next_state.bresp = lscrb_pkg::AXI_RESP_SLVERR;
            endcase
        end


        // read: one cycle after acceptance
        // data is frozen at acceptance so a stalled rready sees no change
        if (s_axi_rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = rd_word;
            next_state.rresp  = rd_hit ? lscrb_pkg::AXI_RESP_OKAY : lscrb_pkg::AXI_RESP_SLVERR;
        end


        if (transmit_load_req && in_run &&
            state.global_control[lscrb_pkg::TX_ENABLE_POS]) begin
            next_state.shift = {state.tx_low, state.tx_high};
            next_state.loads = 1'b1;
        end


        // module reset clears engine-facing state, keeps registers
        // clear comes last so it wins over a load in the same cycle
        if (!in_run) begin
            next_state.shift = 64'h0000_0000_0000_0000;
            next_state.loads = 1'b0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // one address/data held at a time; refused until the response drains
    // readies are combinational, every other axi output comes from flops
    assign s_axi_awready = !state.aw_held && !state.bvalid;
    assign s_axi_wready  = !state.w_held && !state.bvalid;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = !state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;


    // engine-facing run, mode and config
    assign module_run              = state.reset_bit;
    assign lin_mode                = in_lin;
    assign receive_enable_bit      = state.global_control[lscrb_pkg::RX_ENABLE_POS];
    // handshake: ack when the request would be taken this cycle
    assign transmit_load_ack       = transmit_load_req && in_run &&
                                     state.global_control[lscrb_pkg::TX_ENABLE_POS];
    assign transmit_shift_register = state.shift;
    assign frame_format            = state.frame_format;
    assign identifier_cfg          = state.identifier;
    assign max_baud_select         = state.max_baud;
    assign test_control            = state.test_control;

endmodule

`default_nettype wire

// ### test/lscrb_engine_model.sv
// stand-in for the serial engine on the bank's engine-side ports
// assumes one clock with the bank; values it shows are fixed per run
`default_nettype none

module lscrb_engine_model #(
    parameter logic [31:0] RX_HIGH = 32'h0000_0000,
    parameter logic [7:0]  RX_ID   = 8'h00,
    parameter logic [7:0]  RX_MASK = 8'h00,
    parameter logic [7:0]  TX_MASK = 8'h00
) (
    // clock, reset, bench command
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        want_load,
    // bank engine side
    output logic             transmit_load_req,
    input  wire logic        transmit_load_ack,
    output logic [31:0]      receive_data_high,
    output logic [7:0]       received_id,
    output logic [7:0]       rx_id_mask,
    output logic [7:0]       tx_id_mask
);
    // ********************
    // receive values and load request
    // ********************
    assign receive_data_high = RX_HIGH;
    assign received_id       = RX_ID;
    assign rx_id_mask        = RX_MASK;
    assign tx_id_mask        = TX_MASK;

    // waits for transfer
    // request stays up until taken, so a disabled transmitter stalls it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transmit_load_req <= 1'b0;
        end else if (transmit_load_ack) begin
            transmit_load_req <= 1'b0;
        end else if (want_load) begin
            transmit_load_req <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### test/lscrb_bank_sva.sv
// checker for the lin/sci register bank, bound to each bank
// assumes at most one write in flight, so one capture slot suffices
`default_nettype none

module lscrb_bank_sva (
    // clock, reset, write channels
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    // gate and engine side
    input wire logic        privileged_write_gate,
    input wire logic        module_run,
    input wire logic        lin_mode,
    input wire logic        transmit_load_req,
    input wire logic        transmit_load_ack,
    input wire logic [63:0] transmit_shift_register,
    input wire logic [31:0] frame_format,
    input wire logic [31:0] identifier_cfg
);
    // ********************
    // write capture and properties
    // ********************
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;

    // keep each half as taken; the commit edge compares against it
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata;
            ws <= s_axi_wstrb;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // commit edge of a write to one address; gate and mode seen one edge back
    sequence s_commit(logic [7:0] a);
        $rose(s_axi_bvalid) && wa == a;
    endsequence

    property p_run_set;
        s_commit(lscrb_pkg::ADDR_MODULE_RESET_CONTROL) ##0
            ($past(privileged_write_gate) && ws[0]) |-> module_run == wd[0];
    endproperty
    property p_run_hold;
        s_commit(lscrb_pkg::ADDR_MODULE_RESET_CONTROL) ##0
            !$past(privileged_write_gate) |-> $stable(module_run);
    endproperty
    property p_lin_wr;
        s_commit(lscrb_pkg::ADDR_IDENTIFIER) ##0 ($past(lin_mode) && ws[1:0] == 2'h3)
            |-> identifier_cfg[15:0] == wd[15:0];
    endproperty
    property p_lin_block;
        s_commit(lscrb_pkg::ADDR_IDENTIFIER) ##0 !$past(lin_mode)
            |-> $stable(identifier_cfg[15:0]);
    endproperty
    property p_cmp_block;
        s_commit(lscrb_pkg::ADDR_FRAME_FORMAT) ##0 $past(lin_mode)
            |-> $stable(frame_format[2:0]);
    endproperty
    property p_ack;
        transmit_load_ack |-> transmit_load_req && module_run;
    endproperty
    property p_no_load;
        module_run && !transmit_load_ack |=> !module_run || $stable(transmit_shift_register);
    endproperty
    property p_clear;
        !module_run |=> transmit_shift_register == 64'h0;
    endproperty

    a_run_set: assert property (p_run_set)
        else $error("reset bit write not applied");
    a_run_hold: assert property (p_run_hold)
        else $error("reset bit changed with gate closed");
    a_lin_wr: assert property (p_lin_wr)
        else $error("identifier not written in lin mode");
    a_lin_block: assert property (p_lin_block)
        else $error("identifier written outside lin mode");
    a_cmp_block: assert property (p_cmp_block)
        else $error("character field written in lin mode");
    a_ack: assert property (p_ack)
        else $error("load acknowledged without request or run");
    a_no_load: assert property (p_no_load)
        else $error("shift register changed without a load");
    a_clear: assert property (p_clear)
        else $error("shift register not cleared in module reset");
endmodule

bind lscrb_bank lscrb_bank_sva u_sva (.*);

`default_nettype wire

// ### test/lin_sci_control_register_bank_bench.sv
// self-checking bench for the lin/sci register bank over axi4-lite
// assumes the engine model on the engine side and the bound checker
`default_nettype none

module lin_sci_control_register_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ********************
    // signals, models, tasks
    // ********************
    typedef struct packed {
        logic        w;
        logic [31:0] d;
        logic [1:0]  r;
    } lscrb_note_t;

    localparam logic [31:0] RXH = 32'h3C5A_96E1;
    localparam logic [7:0]  RID = 8'h5A, RXM = 8'h3C, TXM = 8'hC3;
    localparam logic [1:0]  OK = lscrb_pkg::AXI_RESP_OKAY;
    localparam logic [7:0]  A [5] = '{8'h04, 8'h08, 8'h14, 8'h20, 8'h24};
    localparam logic [31:0] MA [5] = '{lscrb_pkg::GCR_MASK_ANY, lscrb_pkg::FMT_MASK_ANY,
        32'h0, 32'h0, lscrb_pkg::TST_MASK_ANY};
    localparam logic [31:0] ML [5] = '{lscrb_pkg::GCR_MASK_LIN, 32'h0,
        lscrb_pkg::ID_MASK_LIN, lscrb_pkg::MBR_MASK_LIN, 32'h0};
    localparam logic [31:0] MC [5] = '{lscrb_pkg::GCR_MASK_COMPAT,
        lscrb_pkg::FMT_MASK_COMPAT, 32'h0, 32'h0, 32'h0};

    logic        aclk = 1'b0, aresetn = 1'b0, privileged_write_gate = 1'b0, want_load = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, receive_data_high, frame_format, identifier_cfg;
    logic [31:0] max_baud_select, test_control;
    logic        module_run, lin_mode, receive_enable_bit, transmit_load_req, transmit_load_ack;
    logic [63:0] transmit_shift_register;
    logic [7:0]  received_id, rx_id_mask, tx_id_mask;
    logic [31:0] seed = 32'h0000_FE4B, m [5] = '{default: 32'h0};
    int          num_errors = 0, samples_checked = 0, cyc = 0;
    lscrb_note_t q [$], n;

    lscrb_bank u_dut (.*);
    lscrb_engine_model #(.RX_HIGH(RXH), .RX_ID(RID), .RX_MASK(RXM), .TX_MASK(TXM)) u_eng (.*);

    initial forever #25 aclk = ~aclk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] bm(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    task automatic wrap_up();
        if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_val(input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
        chk_val({62'h0, e}, {62'h0, g});
    endtask

    // one transfer; ready held back a cycle at random to stall the bank
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tw, tr, tv, td;
        logic [31:0] r;
        r = xs();
        q.push_back(lscrb_note_t'({w, ed, er}));
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w & r[0];
        s_axi_rready <= !w & r[0];
        do begin
            @(negedge aclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tr = s_axi_arvalid & s_axi_arready;
            tv = s_axi_bvalid | s_axi_rvalid;
            td = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
            @(posedge aclk);
            // released payload is inverted so a stale value cannot pass
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (tr) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (tv && !td) begin
                s_axi_bready <= w;
                s_axi_rready <= !w;
            end
        end while (td !== 1'b1);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask

    // result watcher: oldest note against each accepted response
    always @(negedge aclk) begin
        if ((s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready) === 1'b1) begin
            n = q.pop_front();
            chk_resp(n.r, n.w ? s_axi_bresp : s_axi_rresp);
            if (!n.w) chk_val({32'h0, n.d}, {32'h0, s_axi_rdata});
        end
    end

    // hang guard, far above the few hundred cycles of the run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        logic [31:0] v, wm, lo, hi;
        logic [3:0]  s;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0, 4'h0, 32'h0, OK);
        bus(1'b0, 8'h2C, 32'h0, 4'h0, 32'h0, lscrb_pkg::AXI_RESP_SLVERR);
        bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF, 32'h0, OK);
        privileged_write_gate <= 1'b1;
        bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hE, 32'h0, OK);
        bus(1'b0, 8'h00, 32'h0, 4'h0, 32'h0, OK);
        bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF, 32'h0, OK);
        bus(1'b0, 8'h00, 32'h0, 4'h0, 32'h1, OK);
        // each of the five config registers written in both modes
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 5; j++) begin
                v = xs();
                s = {v[31:30], 2'h3};
                if (j == 0) begin
                    s = 4'hF;
                    v[6] = i[0];
                    v[25] = 1'b1;
                    v[24] = i[1];
                end
                wm = bm(s) & (MA[j] | (m[0][6] ? ML[j] : MC[j]));
                m[j] = (m[j] & ~wm) | (v & wm);
                bus(1'b1, A[j], v, s, 32'h0, OK);
                v = m[j] | (j == 2 ? {8'h0, RID, 16'h0} : 32'h0);
                bus(1'b0, A[j], 32'h0, 4'h0, v, OK);
            end
            chk_val({62'h0, m[0][6], m[0][24]}, {62'h0, lin_mode, receive_enable_bit});
            chk_val({m[3], m[4]}, {max_baud_select, test_control});
        end
        bus(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF, 32'h0, OK);
        bus(1'b0, 8'h10, 32'h0, 4'h0, {8'h0, RXM, 8'h0, TXM}, OK);
        bus(1'b0, 8'h0C, 32'h0, 4'h0, RXH, OK);
        // waiting load held off until transmit is enabled
        lo = xs();
        hi = xs();
        bus(1'b1, 8'h18, lo, 4'hF, 32'h0, OK);
        bus(1'b1, 8'h1C, hi, 4'hF, 32'h0, OK);
        m[0][25] = 1'b0;
        bus(1'b1, 8'h04, m[0], 4'hF, 32'h0, OK);
        want_load <= 1'b1;
        repeat (4) @(posedge aclk);
        want_load <= 1'b0;
        @(negedge aclk);
        chk_val(64'h0, transmit_shift_register);
        m[0][25] = 1'b1;
        bus(1'b1, 8'h04, m[0], 4'hF, 32'h0, OK);
        @(negedge aclk);
        chk_val({lo, hi}, transmit_shift_register);
        bus(1'b0, 8'h28, 32'h0, 4'h0, 32'h1, OK);
        bus(1'b1, 8'h00, 32'h0, 4'hF, 32'h0, OK);
        @(negedge aclk);
        chk_val(64'h0, {63'h0, module_run});
        chk_val(64'h0, transmit_shift_register);
        bus(1'b0, 8'h14, 32'h0, 4'h0, m[2] | {8'h0, RID, 16'h0}, OK);
        wrap_up();
    end
endmodule

`default_nettype wire
